/* hw/mac_csr_pkg.sv */
// Purpose: constants shared by the station address, hash and phy management block
// Assumes: apb byte address equals four times the register index
// Notes: none
`default_nettype none
package mac_csr_pkg;
    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_ADDR_HIGH = 8'h02;
    localparam logic [7:0] IDX_ADDR_LOW = 8'h03;
    localparam logic [7:0] IDX_HASH_UPPER = 8'h04;
    localparam logic [7:0] IDX_HASH_LOWER = 8'h05;
    localparam logic [7:0] IDX_MGMT_ACCESS = 8'h06;
    localparam logic [7:0] IDX_MGMT_DATA = 8'h07;
    localparam logic [7:0] IDX_FRAME_CTRL = 8'h10;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_ADDR_HIGH = 32'h0000ffff;
    localparam logic [31:0] RST_ADDR_LOW = 32'h0fffffff;
    localparam logic [31:0] RST_HASH = 32'h00000000;
    localparam logic [31:0] RST_MGMT = 32'h00000000;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ADDR_HIGH_MSB = 15;
    localparam int PHY_ADDR_MSB = 15;
    localparam int PHY_ADDR_LSB = 11;
    localparam int REG_IDX_MSB = 10;
    localparam int REG_IDX_LSB = 6;
    localparam int WRITE_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam int DATA_MSB = 15;
    localparam int PASS_ALL_BIT = 0;
    localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h01;
    // ------------------------------------------------------------------
    // management frame timing
    // ------------------------------------------------------------------
    localparam int MDC_HALF_PERIOD_NS = 200;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MDC_HALF_CYCLES = (MDC_HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_BITS = 64;
    localparam int TA_FIRST_BIT = 46;
    localparam int DATA_FIRST_BIT = 48;
endpackage : mac_csr_pkg
`default_nettype wire

/* hw/mgmt_frame_if.sv */
// Purpose: carries a phy management request between the register bank and framer
// Assumes: one request at a time, start is a pulse
// Notes: none
`default_nettype none
interface mgmt_frame_if;
    logic start;
    logic isWrite;
    logic [4:0] phyAddr;
    logic [4:0] regIndex;
    logic [15:0] wrData;
    logic done;
    logic [15:0] rdData;
    modport ctrl (output start, output isWrite, output phyAddr, output regIndex,
                  output wrData, input done, input rdData);
    modport framer (input start, input isWrite, input phyAddr, input regIndex,
                    input wrData, output done, output rdData);
endinterface : mgmt_frame_if
`default_nettype wire

/* hw/mgmt_framer.sv */
// Purpose: shifts one clause 22 management frame out on mdc and mdio
// Assumes: phy samples mdio on rising mdc, drives read data after falling mdc
// Notes: 32 preamble ones, start, opcode, addresses, turnaround, 16 data bits
`default_nettype none
module mgmt_framer (
    input wire logic clk,
    input wire logic rstn,
    mgmt_frame_if.framer req,
    output logic mdc,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic mdioIn
);
    // ------------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        SHIFT = 2'b01,
        FINISH = 2'b10
    } framer_state_type;

    framer_state_type state_reg, state_next;
    logic [7:0] div_reg, div_next;
    logic [6:0] bit_reg, bit_next;
    logic [63:0] shift_reg, shift_next;
    logic write_reg, write_next;
    logic [15:0] rd_reg, rd_next;
    logic mdc_reg, mdc_next;
    logic oe_reg, oe_next;
    logic done_reg, done_next;

    // next frame state, one bit per full mdc period
    always_comb begin
        state_next = state_reg;
        div_next = div_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        write_next = write_reg;
        rd_next = rd_reg;
        mdc_next = mdc_reg;
        oe_next = oe_reg;
        done_next = 1'b0;
        case (state_reg)
            IDLE: begin
                mdc_next = 1'b0;
                oe_next = 1'b0;
                if (req.start) begin
                    write_next = req.isWrite;
                    shift_next = {32'hffffffff, 2'b01, req.isWrite ? 2'b01 : 2'b10,
                                  req.phyAddr, req.regIndex, 2'b10, req.wrData};
                    bit_next = 7'h00;
                    div_next = 8'h00;
                    oe_next = 1'b1;
                    state_next = SHIFT;
                end
            end
            SHIFT: begin
                if (div_reg == 8'(mac_csr_pkg::MDC_HALF_CYCLES - 1)) begin
                    div_next = 8'h00;
                    mdc_next = ~mdc_reg;
                    if (mdc_reg) begin
                        // falling edge: present the next bit
                        shift_next = {shift_reg[62:0], 1'b0};
                        bit_next = bit_reg + 7'h01;
                        if (bit_reg == 7'(mac_csr_pkg::FRAME_BITS - 1)) begin
                            state_next = FINISH;
                            oe_next = 1'b0;
                        end else if (!write_reg &&
                                     bit_reg == 7'(mac_csr_pkg::TA_FIRST_BIT - 1)) begin
                            oe_next = 1'b0;
                        end
                    end else if (!write_reg &&
                                 bit_reg >= 7'(mac_csr_pkg::DATA_FIRST_BIT)) begin
                        // rising edge: capture read data
                        rd_next = {rd_reg[14:0], mdioIn};
                    end
                end else begin
                    div_next = div_reg + 8'h01;
                end
            end
            FINISH: begin
                done_next = 1'b1;
                state_next = IDLE;
            end
            default: begin
                state_next = IDLE;
            end
        endcase
    end

    // register the frame state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= IDLE;
            div_reg <= 8'h00;
            bit_reg <= 7'h00;
            shift_reg <= 64'h0;
            write_reg <= 1'b0;
            rd_reg <= 16'h0000;
            mdc_reg <= 1'b0;
            oe_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            write_reg <= write_next;
            rd_reg <= rd_next;
            mdc_reg <= mdc_next;
            oe_reg <= oe_next;
            done_reg <= done_next;
        end
    end

    // outputs
    assign mdc = mdc_reg;
    assign mdioOut = shift_reg[63];
    assign mdioOe = oe_reg;
    assign req.done = done_reg;
    assign req.rdData = rd_reg;
endmodule : mgmt_framer
`default_nettype wire

/* hw/mac_addr_hash_mii_csr.sv */
// Purpose: station address, group hash filter and phy management registers
// Assumes: apb slave, zero wait states, eeprom loader presents one byte per strobe
// Notes: writes to the management registers while busy are dropped
`default_nettype none
// How it works
// RULE1: address high holds station bits 47:32 in 15:0, upper bits read zero
// RULE2: eeprom bytes 5 and 6 load address high low and high bytes
// RULE3: eeprom bytes 1 to 4 fill address low, least significant first
// RULE4: address high resets to 0000ffff before any eeprom load
// RULE5: host writes after init replace the address the block uses
// RULE6: address low byte 0 is first on the wire, high byte 1 sixth
// RULE7: top hash bit picks upper or lower register, five bits pick the bit
// RULE8: group frame accepted when the selected hash bit is one
// RULE9: pass-all setting accepts every group frame
// RULE10: hash table is upper and lower registers, both reset zero
// RULE11: software writes phy address 00001 on each access register write
// RULE12: access bits 10:6 name the phy register
// RULE13: bit 1 set writes from data register, clear reads into it
// RULE14: software polls busy clear before writing, starts with busy one
// RULE15: access starts on busy written one, busy clears on completion
// RULE16: software keeps data register steady during a phy write
// RULE17: read data valid in data register only after busy clears
// RULE18: data register bits 15:0 carry the sixteen bit value
// RULE19: accesses are clause 22 frames, reserved access bits ignored
module mac_addr_hash_mii_csr (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic eepromValid,
    input wire logic [2:0] eepromIndex,
    input wire logic [7:0] eepromByte,
    input wire logic [5:0] hashIndex,
    output logic groupAccept,
    output logic [47:0] stationAddress,
    output logic mdc,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic mdioIn
);
    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic access;
    logic wrEn;
    logic [7:0] index;
    logic mapped;

    // register index of a byte address, taken from address bits 9:2
    function automatic logic [7:0] word_index(input logic [11:0] a);
        word_index = a[9:2];
    endfunction : word_index

    function automatic logic is_mapped(input logic [11:0] a);
        logic [7:0] i;
        i = word_index(a);
        is_mapped = (a[1:0] == 2'b00) && (a[11:10] == 2'b00) &&
                    ((i >= mac_csr_pkg::IDX_ADDR_HIGH && i <= mac_csr_pkg::IDX_MGMT_DATA) ||
                     i == mac_csr_pkg::IDX_FRAME_CTRL);
    endfunction : is_mapped

    assign access = psel && penable;
    assign index = word_index(paddr);
    assign mapped = is_mapped(paddr);
    assign wrEn = access && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [15:0] addrHigh_reg, addrHigh_next;
    logic [31:0] addrLow_reg, addrLow_next;
    logic [31:0] hashUpper_reg, hashUpper_next;
    logic [31:0] hashLower_reg, hashLower_next;
    logic [4:0] phyAddr_reg, phyAddr_next;
    logic [4:0] regIndex_reg, regIndex_next;
    logic write_reg, write_next;
    logic busy_reg, busy_next;
    logic [15:0] data_reg, data_next;
    logic passAll_reg, passAll_next;
    logic start_reg, start_next;
    logic [31:0] rdata_reg, rdata_next;

    mgmt_frame_if frame ();

    // next register values from eeprom load, bus writes and frame completion
    always_comb begin
        addrHigh_next = addrHigh_reg;
        addrLow_next = addrLow_reg;
        hashUpper_next = hashUpper_reg;
        hashLower_next = hashLower_reg;
        phyAddr_next = phyAddr_reg;
        regIndex_next = regIndex_reg;
        write_next = write_reg;
        busy_next = busy_reg;
        data_next = data_reg;
        passAll_next = passAll_reg;
        start_next = 1'b0;
        // eeprom bytes land at their wire positions
        if (eepromValid) begin
            case (eepromIndex)
                3'h1: addrLow_next[7:0] = eepromByte; // RULE3
                3'h2: addrLow_next[15:8] = eepromByte; // RULE3
                3'h3: addrLow_next[23:16] = eepromByte; // RULE3
                3'h4: addrLow_next[31:24] = eepromByte; // RULE3
                3'h5: addrHigh_next[7:0] = eepromByte; // RULE2
                3'h6: addrHigh_next[15:8] = eepromByte; // RULE2
                default: begin
                end
            endcase
        end
        if (wrEn) begin
            case (index)
                mac_csr_pkg::IDX_ADDR_HIGH: begin
                    addrHigh_next = pwdata[mac_csr_pkg::ADDR_HIGH_MSB:0]; // RULE1 RULE5
                end
                mac_csr_pkg::IDX_ADDR_LOW: begin
                    addrLow_next = pwdata; // RULE5
                end
                mac_csr_pkg::IDX_HASH_UPPER: begin
                    hashUpper_next = pwdata; // RULE10
                end
                mac_csr_pkg::IDX_HASH_LOWER: begin
                    hashLower_next = pwdata; // RULE10
                end
                mac_csr_pkg::IDX_MGMT_ACCESS: begin
                    if (!busy_reg) begin
                        // reserved bits 31:16 and 5:2 are not stored
                        phyAddr_next = pwdata[mac_csr_pkg::PHY_ADDR_MSB:mac_csr_pkg::PHY_ADDR_LSB]; // RULE11 RULE19
                        regIndex_next = pwdata[mac_csr_pkg::REG_IDX_MSB:mac_csr_pkg::REG_IDX_LSB]; // RULE12
                        write_next = pwdata[mac_csr_pkg::WRITE_BIT]; // RULE13
                        if (pwdata[mac_csr_pkg::BUSY_BIT]) begin
                            busy_next = 1'b1; // RULE15
                            start_next = 1'b1; // RULE15
                        end
                    end
                end
                mac_csr_pkg::IDX_MGMT_DATA: begin
                    if (!busy_reg) begin
                        data_next = pwdata[mac_csr_pkg::DATA_MSB:0]; // RULE16 RULE18
                    end
                end
                mac_csr_pkg::IDX_FRAME_CTRL: begin
                    passAll_next = pwdata[mac_csr_pkg::PASS_ALL_BIT]; // RULE9
                end
                default: begin
                end
            endcase
        end
        // frame completion: read data lands together with busy clearing
        if (frame.done) begin
            busy_next = 1'b0; // RULE15 RULE17
            if (!write_reg) begin
                data_next = frame.rdData; // RULE13 RULE17
            end
        end
    end

    // read mux, data comes out of a register
    always_comb begin
        rdata_next = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            case (word_index(paddr))
                mac_csr_pkg::IDX_ADDR_HIGH: rdata_next = {16'h0000, addrHigh_reg}; // RULE1
                mac_csr_pkg::IDX_ADDR_LOW: rdata_next = addrLow_reg;
                mac_csr_pkg::IDX_HASH_UPPER: rdata_next = hashUpper_reg;
                mac_csr_pkg::IDX_HASH_LOWER: rdata_next = hashLower_reg;
                mac_csr_pkg::IDX_MGMT_ACCESS: begin
                    rdata_next = {16'h0000, phyAddr_reg, regIndex_reg, 4'h0,
                                  write_reg, busy_reg};
                end
                mac_csr_pkg::IDX_MGMT_DATA: rdata_next = {16'h0000, data_reg}; // RULE18
                mac_csr_pkg::IDX_FRAME_CTRL: rdata_next = {31'h00000000, passAll_reg};
                default: rdata_next = 32'h00000000;
            endcase
            if (!is_mapped(paddr)) begin
                rdata_next = 32'h00000000;
            end
        end
    end

    // register everything
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addrHigh_reg <= mac_csr_pkg::RST_ADDR_HIGH[15:0]; // RULE4
            addrLow_reg <= mac_csr_pkg::RST_ADDR_LOW;
            hashUpper_reg <= mac_csr_pkg::RST_HASH; // RULE10
            hashLower_reg <= mac_csr_pkg::RST_HASH; // RULE10
            phyAddr_reg <= mac_csr_pkg::RST_MGMT[15:11];
            regIndex_reg <= mac_csr_pkg::RST_MGMT[10:6];
            write_reg <= 1'b0;
            busy_reg <= 1'b0;
            data_reg <= mac_csr_pkg::RST_MGMT[15:0];
            passAll_reg <= 1'b0;
            start_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            addrHigh_reg <= addrHigh_next;
            addrLow_reg <= addrLow_next;
            hashUpper_reg <= hashUpper_next;
            hashLower_reg <= hashLower_next;
            phyAddr_reg <= phyAddr_next;
            regIndex_reg <= regIndex_next;
            write_reg <= write_next;
            busy_reg <= busy_next;
            data_reg <= data_next;
            passAll_reg <= passAll_next;
            start_reg <= start_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // filter and address outputs
    // ------------------------------------------------------------------
    logic [63:0] hashTable;
    assign hashTable = {hashUpper_reg, hashLower_reg}; // RULE10
    // index 0 is lower bit 0, index 63 is upper bit 31
    assign groupAccept = passAll_reg || hashTable[hashIndex]; // RULE7 RULE8 RULE9
    // wire order first..sixth as bits 7:0 .. 47:40
    assign stationAddress = {addrHigh_reg, addrLow_reg}; // RULE6
    assign prdata = rdata_reg;

    // ------------------------------------------------------------------
    // management frame engine
    // ------------------------------------------------------------------
    assign frame.start = start_reg;
    assign frame.isWrite = write_reg;
    assign frame.phyAddr = phyAddr_reg;
    assign frame.regIndex = regIndex_reg;
    assign frame.wrData = data_reg;

    // clause 22 framer
    mgmt_framer u_framer (
        .clk(clk),
        .rstn(rstn),
        .req(frame), // RULE19
        .mdc(mdc),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe),
        .mdioIn(mdioIn)
    );
endmodule : mac_addr_hash_mii_csr
`default_nettype wire

/* testbench/mac_csr_props.sv */
// Purpose: concurrent checks on the address, hash and phy management block
// Assumes: zero wait apb, byte address four times the register index
// Notes: bound to every instance of the block
`default_nettype none
module mac_csr_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic eepromValid,
    input wire logic [2:0] eepromIndex,
    input wire logic [7:0] eepromByte,
    input wire logic [5:0] hashIndex,
    input wire logic groupAccept,
    input wire logic [47:0] stationAddress,
    input wire logic mdc,
    input wire logic mdioOut,
    input wire logic mdioOe,
    input wire logic mdioIn
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic hostWr;
    // host write accepted in this cycle
    assign hostWr = psel && penable && pwrite;
    a_err_read_zero: assert property (psel && penable && !pwrite && pslverr
        |-> prdata == 32'h0) else $error("refused read returned data");
    a_eeprom_first: assert property (eepromValid && eepromIndex == 3'd1 && !hostWr
        |=> stationAddress[7:0] == $past(eepromByte)) else $error("first byte not loaded");
    a_eeprom_sixth: assert property (eepromValid && eepromIndex == 3'd6 && !hostWr
        |=> stationAddress[47:40] == $past(eepromByte)) else $error("sixth byte not loaded");
    a_host_high: assert property (hostWr && paddr == 12'h008
        |=> stationAddress[47:32] == 16'($past(pwdata))) else $error("high write lost");
    a_pass_all: assert property (hostWr && paddr == 12'h040 && pwdata[0]
        |=> groupAccept) else $error("pass all ignored");
    a_reset_addr: assert property ($rose(rstn)
        |-> stationAddress == 48'hffff_0fffffff && !groupAccept) else $error("bad reset");
    a_mdc_high: assert property ($rose(mdc) |=> mdc [*8]) else $error("mdc high too short");
    a_mdc_low: assert property ($fell(mdc) |=> !mdc [*8]) else $error("mdc low too short");
    a_access_start: assert property (hostWr && paddr == 12'h018 && pwdata[0] && !mdioOe
        && !mdc |-> ##[1:10] mdioOe) else $error("access did not start");
    a_no_start: assert property (hostWr && paddr == 12'h018 && !pwdata[0] && !mdioOe
        && !mdc |=> !mdioOe [*8]) else $error("access started without busy");
    c_frame: cover property ($rose(mdioOe));
    c_refused: cover property (pslverr);
    c_accept: cover property (groupAccept);
endmodule : mac_csr_props
bind mac_addr_hash_mii_csr mac_csr_props props_u (.*);
`default_nettype wire

/* testbench/phy_mgmt_model.sv */
// Purpose: behavioural phy management port, decodes frames and answers reads
// Assumes: samples on rising mdc, drives read bits after falling mdc
// Notes: the line has a pull-up, so it reads one when nobody drives
`default_nettype none
module phy_mgmt_model #(
    parameter logic [15:0] READ_VALUE = 16'hc3a5
) (
    input wire logic mdc,
    input wire logic mdioOut,
    input wire logic mdioOe,
    output logic mdioIn,
    output logic [31:0] lastFrame,
    output int frameCount
);
    int cnt = -1;
    int frames = 0;
    logic drv = 1'b0;
    logic drvBit = 1'b1;
    logic [31:0] bits = 32'h0;
    // wire level from both drivers and the pull-up
    assign mdioIn = mdioOe ? mdioOut : (drv ? drvBit : 1'b1);
    assign frameCount = frames;
    // capture start bit to last data bit, one per rising mdc
    always @(posedge mdc) begin
        if (cnt < 0 && mdioOe && mdioIn === 1'b0)
            cnt = 32;
        else if (cnt >= 0)
            cnt = cnt + 1;
        if (cnt >= 32)
            bits[63 - cnt] = mdioIn;
        if (cnt == 63) begin
            lastFrame = bits;
            frames = frames + 1;
            cnt = -1;
        end
    end
    // read answer: turnaround zero, then data msb first
    always @(negedge mdc) begin
        drv = cnt >= 46 && cnt <= 62 && bits[29:28] == 2'b10;
        drvBit = (cnt == 46) ? 1'b0 : READ_VALUE[4'(62 - cnt)];
    end
endmodule : phy_mgmt_model
`default_nettype wire

/* testbench/mac_addr_hash_mii_csr_tb_top.sv */
// Purpose: self-checking bench for the address, hash and phy management block
// Assumes: zero wait apb slave, phy model on the management pins
// Notes: one task per scenario, inputs change on rising edges
`default_nettype none
module mac_addr_hash_mii_csr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, eepromValid, groupAccept;
    logic mdc, mdioOut, mdioOe, mdioIn, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, lastFrame;
    logic [2:0] eepromIndex;
    logic [7:0] eepromByte;
    logic [5:0] hashIndex;
    logic [47:0] stationAddress;
    int frameCount, fails = 0, total_checks = 0;
    mac_addr_hash_mii_csr dut_u (.*);
    phy_mgmt_model phy_u (.mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdioIn(mdioIn),
        .lastFrame(lastFrame), .frameCount(frameCount));
    // ---------------------------------------------------------------
    // clock, checks and bus cycles
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // setup cycle, then access phase held until pready is sampled high at a rising edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic reset_values();
        logic [31:0] v [6] = '{32'h0000ffff, 32'h0fffffff, 0, 0, 0, 0};
        check("station", stationAddress, 48'hffff_0fffffff);
        for (int i = 0; i < 6; i++) begin
            xfer(12'h008 + 12'(4 * i), 1'b0, 32'h0);
            check("reset value", rd, v[i]);
        end
    endtask : reset_values
    task automatic eeprom_load();
        logic [7:0] b [8] = '{8'h55, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'h66};
        for (int i = 0; i < 8; i++) begin
            eepromValid <= 1'b1;
            eepromIndex <= 3'(i);
            eepromByte <= b[i];
            @(posedge clk);
        end
        eepromValid <= 1'b0;
        @(posedge clk);
        check("station", stationAddress, 48'hbc9a_78563412);
        xfer(12'h00c, 1'b0, 32'h0);
        check("addr low", rd, 32'h78563412);
        xfer(12'h008, 1'b0, 32'h0);
        check("addr high", rd, 32'h0000bc9a);
    endtask : eeprom_load
    task automatic host_writes();
        xfer(12'h008, 1'b1, 32'hffffa1b2);
        xfer(12'h00c, 1'b1, 32'h01020304);
        check("station", stationAddress, 48'ha1b2_01020304);
        xfer(12'h008, 1'b0, 32'h0);
        check("addr high", rd, 32'h0000a1b2);
        xfer(12'h020, 1'b0, 32'h0);
        check("unmapped", {e, rd}, {1'b1, 32'h0});
    endtask : host_writes
    task automatic hash_filter();
        xfer(12'h014, 1'b1, 32'h00000001);
        xfer(12'h010, 1'b1, 32'h80000000);
        for (int m = 0; m < 3; m++) begin
            xfer(12'h040, 1'b1, 32'(m & 1));
            for (int i = 0; i < 64; i++) begin
                hashIndex <= 6'(i);
                @(posedge clk);
                check("accept", groupAccept, m == 1 || i == 0 || i == 63);
            end
        end
        xfer(12'h010, 1'b0, 32'h0);
        check("hash upper", rd, 32'h80000000);
    endtask : hash_filter
    task automatic phy_access(input logic [31:0] cmd, input logic [31:0] frm);
        int n = frameCount;
        xfer(12'h018, 1'b1, cmd);
        xfer(12'h018, 1'b0, 32'h0);
        check("busy set", rd[0], 1'b1);
        for (int k = 0; k < 2000 && rd[0] === 1'b1; k++)
            xfer(12'h018, 1'b0, 32'h0);
        check("access reg", rd, cmd & 32'h0000ffc2);
        check("frames", 32'(frameCount - n), 32'd1);
        check("frame", lastFrame, frm);
    endtask : phy_access
    task automatic phy_traffic();
        xfer(12'h018, 1'b1, 32'h00000880);
        xfer(12'h018, 1'b0, 32'h0);
        check("no start", {mdioOe, 16'(frameCount), rd[15:0]}, {1'b0, 16'h0000, 16'h0880});
        xfer(12'h01c, 1'b1, 32'h0000beef);
        phy_access(32'hffff0abf, 32'h50aabeef);
        xfer(12'h01c, 1'b0, 32'h0);
        check("write data", rd, 32'h0000beef);
        phy_access(32'h000008c1, 32'h608ec3a5);
        xfer(12'h01c, 1'b0, 32'h0);
        check("read data", rd, 32'h0000c3a5);
    endtask : phy_traffic
    // main sequence and watchdog
    initial begin
        {rstn, psel, penable, pwrite, eepromValid} = 5'h0;
        {paddr, pwdata, eepromIndex, eepromByte, hashIndex} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        reset_values();
        eeprom_load();
        host_writes();
        hash_filter();
        phy_traffic();
        wrap_up();
    end
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule : mac_addr_hash_mii_csr_tb_top
`default_nettype wire
